// ===== shared/sssr_regs.svh
// constants of the serial sram slave: field positions, widths and reset values
`ifndef SSSR_REGS_SVH
`define SSSR_REGS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define SSSR_ADDR_BITS   15
`define SSSR_PAGE_BITS   5
`define SSSR_WORD_BITS   8
`define SSSR_CNT_BITS    4

// ----------------------------------------------------------------------------
// phase lengths, last bit index
// ----------------------------------------------------------------------------
`define SSSR_CMD_LAST    4'h7
`define SSSR_ADDR_LAST   4'hf
`define SSSR_WORD_LAST   4'h7

// ----------------------------------------------------------------------------
// status register
// ----------------------------------------------------------------------------
`define SSSR_MODE_MSB    7
`define SSSR_MODE_LSB    6
`define SSSR_STATUS_RST  8'h00

`endif

// ===== shared/sssr_pkg.sv
// types shared by the serial sram slave and its array
`include "sssr_regs.svh"

package sssr_pkg;

    // ------------------------------------------------------------------------
    // instruction opcodes
    // ------------------------------------------------------------------------
    typedef enum logic [7:0]
    {
        write_status_cmd = 8'h01,
        write_cmd        = 8'h02,
        read_cmd         = 8'h03,
        read_status_cmd  = 8'h05
    } sssr_cmd_type;

    // ------------------------------------------------------------------------
    // sequencing modes held in the status register
    // ------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        mode_word  = 2'h0,
        mode_burst = 2'h1,
        mode_page  = 2'h2,
        mode_rsvd  = 2'h3
    } sssr_mode_type;

    // ------------------------------------------------------------------------
    // serial phases, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [6:0]
    {
        st_cmd   = 7'h01,
        st_addr  = 7'h02,
        st_rdata = 7'h04,
        st_wdata = 7'h08,
        st_rstat = 7'h10,
        st_wstat = 7'h20,
        st_ign   = 7'h40
    } sssr_state_type;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed
    {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
    } sssr_pins_type;

    typedef struct packed
    {
        logic                        en;
        logic [`SSSR_ADDR_BITS-1:0]  addr;
        logic [`SSSR_WORD_BITS-1:0]  data;
    } sssr_wr_type;

endpackage : sssr_pkg

// ===== src/sssr_mem.sv
// storage array of the serial sram: clocked write, direct read
`timescale 1ns/10ps
`include "sssr_regs.svh"

module sssr_mem
#(
    parameter int addr_w = `SSSR_ADDR_BITS,
    parameter int data_w = `SSSR_WORD_BITS
)
(
    // clock
    input  wire logic                  mclk_i,
    // write and read ports
    input  wire sssr_pkg::sssr_wr_type wr_i,
    input  wire logic [addr_w-1:0]     rd_addr_i,
    output logic      [data_w-1:0]     rd_data_o
);
    import sssr_pkg::*;

    logic [data_w-1:0] mem [0:(2**addr_w)-1];

    always_ff @(posedge mclk_i)
    begin
        if (wr_i.en)
        begin
            mem[wr_i.addr] <= wr_i.data;
        end
    end

    assign rd_data_o = mem[rd_addr_i];

endmodule : sssr_mem

// ===== src/sssr_slave.sv
// serial sram slave: instruction, address, read/write streams and pause
`timescale 1ns/10ps
`include "sssr_regs.svh"

// Operation
// - low select is active, high is standby
// - started array write completes despite deselect
// - output undriven whenever select is high
// - input bits taken on clock rising edge
// - output bit changes only after falling edge
// - first rising edge after select starts command
// - pause low suspends without losing sequence state
// - pause acts now if clock low, else fall
// - paused: output undriven, clock and input ignored
// - pause low always turns output off
// - resume continues at the paused bit
// - eight-bit instruction register loaded serially
// - every field shifted most significant bit first
// - opcodes read 03, write 02, status 05/01
// - read takes 16-bit address, top bit ignored
// - page mode wraps within 32-word page
// - burst mode wraps 7fff to 0000
// - read runs until select goes high
// - status write loads mode selecting register
// - after reset idle in standby, select high
module sssr_slave
#(
    parameter int addr_w = `SSSR_ADDR_BITS,
    parameter int page_w = `SSSR_PAGE_BITS
)
(
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    nrst_i,
    // serial link pins, sampled on mclk_i
    input  wire sssr_pkg::sssr_pins_type pins_i,
    // serial output, high enable drives the pin
    output logic                         so_o,
    output logic                         so_oe_o,
    // state seen from outside
    output logic                         standby_o,
    output logic                         held_o
);
    import sssr_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    sssr_state_type            state;
    sssr_state_type            next_state;
    logic [`SSSR_CNT_BITS-1:0] cnt;
    logic [`SSSR_CNT_BITS-1:0] next_cnt;
    logic [15:0]               sr;
    logic [15:0]               next_sr;
    logic [7:0]                instr;
    logic [7:0]                next_instr;
    logic [addr_w-1:0]         ptr;
    logic [addr_w-1:0]         next_ptr;
    logic [7:0]                status;
    logic [7:0]                next_status;
    logic [7:0]                obuf;
    logic [7:0]                next_obuf;
    logic                      drv;
    logic                      next_drv;
    logic                      held;
    logic                      next_held;
    logic                      sck_q;
    logic                      next_so;
    logic                      next_so_oe;
    sssr_wr_type               wr;
    sssr_wr_type               next_wr;
    logic [7:0]                rd_data;
    logic [7:0]                src;
    logic [7:0]                in_byte;
    logic                      selected;
    logic                      rise;
    logic                      fall;
    sssr_mode_type             mode;

    // ------------------------------------------------------------------------
    // address sequencing
    // ------------------------------------------------------------------------
    function automatic logic [addr_w-1:0] advance(input logic [addr_w-1:0] a,
                                                   input sssr_mode_type     m);
        logic [page_w-1:0] low;
        low = a[page_w-1:0] + 1'b1;
        case (m)
            mode_page:  advance = {a[addr_w-1:page_w], low};
            mode_burst: advance = a + 1'b1;
            default:    advance = a;
        endcase
    endfunction : advance

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    sssr_mem #(.addr_w(addr_w), .data_w(`SSSR_WORD_BITS)) u_mem
    (
        .mclk_i    (mclk_i),
        .wr_i      (wr),
        .rd_addr_i (ptr),
        .rd_data_o (rd_data)
    );

    // ------------------------------------------------------------------------
    // link events
    // ------------------------------------------------------------------------
    assign selected = !pins_i.cs_n;
    assign rise     = selected && !held && pins_i.sck && !sck_q;
    assign fall     = selected && !held && pins_i.hold_n
                      && !pins_i.sck && sck_q;
    assign mode     = sssr_mode_type'(status[`SSSR_MODE_MSB:`SSSR_MODE_LSB]);
    assign in_byte  = {sr[6:0], pins_i.si};
    assign src      = (state == st_rdata) ? rd_data : status;

    // ------------------------------------------------------------------------
    // pause tracking
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (!selected)
        begin
            next_held = 1'b0;
        end
        else if (held)
        begin
            next_held = !(pins_i.hold_n && !pins_i.sck);
        end
        else
        begin
            next_held = !pins_i.hold_n && !pins_i.sck;
        end
    end

    // ------------------------------------------------------------------------
    // serial sequencer
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_state  = state;
        next_cnt    = cnt;
        next_sr     = sr;
        next_instr  = instr;
        next_ptr    = ptr;
        next_status = status;
        next_obuf   = obuf;
        next_so     = so_o;
        next_drv    = drv;
        next_wr     = wr;
        next_wr.en  = 1'b0;
        if (!selected)
        begin
            next_state = st_cmd;
            next_cnt   = '0;
            next_drv   = 1'b0;
        end
        else if (rise)
        begin
            next_sr  = {sr[14:0], pins_i.si};
            next_cnt = cnt + 1'b1;
            case (state)
                st_cmd:
                begin
                    if (cnt == `SSSR_CMD_LAST)
                    begin
                        next_cnt   = '0;
                        next_instr = in_byte;
                        case (in_byte)
                            read_cmd:         next_state = st_addr;
                            write_cmd:        next_state = st_addr;
                            read_status_cmd:  next_state = st_rstat;
                            write_status_cmd: next_state = st_wstat;
                            default:          next_state = st_ign;
                        endcase
                    end
                end
                st_addr:
                begin
                    if (cnt == `SSSR_ADDR_LAST)
                    begin
                        next_cnt   = '0;
                        next_ptr   = {sr[addr_w-2:0], pins_i.si};
                        next_state = (instr == read_cmd) ? st_rdata : st_wdata;
                    end
                end
                st_wdata:
                begin
                    if (cnt == `SSSR_WORD_LAST)
                    begin
                        next_cnt     = '0;
                        next_wr.en   = 1'b1;
                        next_wr.addr = ptr;
                        next_wr.data = in_byte;
                        next_ptr     = advance(ptr, mode);
                    end
                end
                st_wstat:
                begin
                    if (cnt == `SSSR_WORD_LAST)
                    begin
                        next_cnt    = '0;
                        next_status = in_byte;
                        next_state  = st_ign;
                    end
                end
                default:
                begin
                    next_cnt = cnt;                                       // reads ignore input
                end
            endcase
        end
        else if (fall && (state == st_rdata || state == st_rstat))
        begin
            next_drv = 1'b1;
            if (cnt == '0)
            begin
                next_so   = src[7];
                next_obuf = {src[6:0], 1'b0};
            end
            else
            begin
                next_so   = obuf[7];
                next_obuf = {obuf[6:0], 1'b0};
            end
            next_cnt = cnt + 1'b1;
            if (cnt == `SSSR_WORD_LAST)
            begin
                next_cnt = '0;
                if (state == st_rdata)
                begin
                    next_ptr = advance(ptr, mode);
                end
            end
        end
        next_so_oe = selected && pins_i.hold_n && !next_held && next_drv;
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state     <= st_cmd;
            cnt       <= '0;
            sr        <= '0;
            instr     <= '0;
            ptr       <= '0;
            status    <= `SSSR_STATUS_RST;
            obuf      <= '0;
            drv       <= 1'b0;
            held      <= 1'b0;
            sck_q     <= 1'b0;
            wr        <= '0;
            so_o      <= 1'b0;
            so_oe_o   <= 1'b0;
            standby_o <= 1'b1;
            held_o    <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            sr        <= next_sr;
            instr     <= next_instr;
            ptr       <= next_ptr;
            status    <= next_status;
            obuf      <= next_obuf;
            drv       <= next_drv;
            held      <= next_held;
            sck_q     <= pins_i.sck;
            wr        <= next_wr;
            so_o      <= next_so;
            so_oe_o   <= next_so_oe;
            standby_o <= pins_i.cs_n;
            held_o    <= next_held;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_cmd_last;
        rise && state == st_cmd && cnt == `SSSR_CMD_LAST;
    endsequence

    sequence s_addr_last;
        rise && state == st_addr && cnt == `SSSR_ADDR_LAST;
    endsequence

    property p_deselect_off;
        pins_i.cs_n |=> !so_oe_o && standby_o;
    endproperty
    a_deselect_off: assert property (p_deselect_off)
        else $error("output driven or not standby while deselected");

    property p_pause_off;
        !pins_i.hold_n |=> !so_oe_o;
    endproperty
    a_pause_off: assert property (p_pause_off)
        else $error("output driven while pause is low");

    property p_fresh_phase;
        pins_i.cs_n |=> state == st_cmd && cnt == '0;
    endproperty
    a_fresh_phase: assert property (p_fresh_phase)
        else $error("deselect did not clear sequence");

    property p_so_on_fall;
        so_o != $past(so_o) |-> $past(fall);
    endproperty
    a_so_on_fall: assert property (p_so_on_fall)
        else $error("serial output changed without falling edge");

    property p_pause_now;
        selected && !pins_i.hold_n && !pins_i.sck |=> held && held_o;
    endproperty
    a_pause_now: assert property (p_pause_now)
        else $error("pause with clock low not taken at once");

    property p_frozen;
        held && selected ##1 selected |-> $stable(state) && $stable(cnt) && $stable(sr);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("sequence changed while paused");

    property p_read_decode;
        s_cmd_last and (in_byte == read_cmd) |=> state == st_addr && instr == read_cmd;
    endproperty
    a_read_decode: assert property (p_read_decode)
        else $error("read opcode not decoded");

    property p_addr_load;
        s_addr_last ##0 selected
            |=> ptr[addr_w-1:1] == $past(sr[addr_w-2:0]) && ptr[0] == $past(pins_i.si)
                && cnt == '0;
    endproperty
    a_addr_load: assert property (p_addr_load)
        else $error("address not loaded from low fifteen bits");

    property p_burst_wrap;
        fall && state == st_rdata && cnt == `SSSR_WORD_LAST && mode == mode_burst
            && ptr == 15'h7fff |=> ptr == 15'h0000;
    endproperty
    a_burst_wrap: assert property (p_burst_wrap)
        else $error("burst counter did not wrap to zero");

    property p_page_wrap;
        fall && state == st_rdata && cnt == `SSSR_WORD_LAST && mode == mode_page
            && ptr[page_w-1:0] == 5'h1f |=> ptr[page_w-1:0] == 5'h00 && $stable(ptr[14:5]);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page pointer left its page");

    property p_write_commits;
        next_wr.en |=> wr.en ##1 !wr.en;
    endproperty
    a_write_commits: assert property (p_write_commits)
        else $error("array write not issued regardless of select");

endmodule : sssr_slave

// ===== dv/sssr_master_model.sv
// serial link master model driving the sram slave pins in clock mode 0
`timescale 1ns/10ps

module sssr_master_model
(
    // clock
    input  wire logic               mclk_i,
    // slave output and its enable
    input  wire logic               so_i,
    input  wire logic               so_oe_i,
    // pins toward the slave
    output sssr_pkg::sssr_pins_type pins_o
);
    import sssr_pkg::*;

    logic so_last = 1'b0;
    logic so_wire;

    // ------------------------------------------------------------------------
    // output wire
    // ------------------------------------------------------------------------
    // an undriven line shows the inverse of its last value, never a stale copy
    always @(posedge mclk_i)
    begin
        if (so_oe_i)
            so_last <= so_i;
    end
    assign so_wire = so_oe_i ? so_i : ~so_last;

    // ------------------------------------------------------------------------
    // pin sequences
    // ------------------------------------------------------------------------
    initial pins_o = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : wait_clk

    // clock idles low; every level lasts two cycles so the slave sees both edges
    task automatic bit_x(input logic b, output logic r);
        pins_o.si <= b;
        wait_clk(2);
        r = so_wire;
        pins_o.sck <= 1'b1;
        wait_clk(2);
        pins_o.sck <= 1'b0;
        wait_clk(2);
    endtask : bit_x

    task automatic select();
        pins_o.cs_n <= 1'b0;
        wait_clk(2);
    endtask : select

    task automatic deselect();
        pins_o.cs_n <= 1'b1;
        wait_clk(3);
    endtask : deselect

    // pause is entered and left only while the clock is low, select held low
    task automatic pause(input logic on);
        pins_o.hold_n <= ~on;
        wait_clk(3);
    endtask : pause

    // clock pulses with random data that a paused slave must ignore
    task automatic wiggle(input int n);
        repeat (n)
        begin
            pins_o.si  <= 1'($urandom);
            pins_o.sck <= 1'b1;
            wait_clk(2);
            pins_o.sck <= 1'b0;
            wait_clk(2);
        end
    endtask : wiggle

endmodule : sssr_master_model

// ===== dv/sssr_slave_tb.sv
// self-checking bench of the serial sram slave
`timescale 1ns/10ps

module sssr_slave_tb;
    import sssr_pkg::*;

    logic          mclk = 1'b0;
    logic          nrst = 1'b0;
    sssr_pins_type pins;
    logic          so;
    logic          so_oe;
    logic          standby;
    logic          held;
    logic [7:0]    exp_q [$];
    logic [7:0]    rx_byte = 8'h00;
    logic          rx_stb = 1'b0;
    int            n_mismatch = 0;
    int            samples_checked = 0;
    int            cycles = 0;

    always #25 mclk = ~mclk;

    sssr_slave i_sssr_slave
    (
        .mclk_i    (mclk),
        .nrst_i    (nrst),
        .pins_i    (pins),
        .so_o      (so),
        .so_oe_o   (so_oe),
        .standby_o (standby),
        .held_o    (held)
    );

    sssr_master_model i_sssr_master_model
    (
        .mclk_i  (mclk),
        .so_i    (so),
        .so_oe_i (so_oe),
        .pins_o  (pins)
    );

    // ------------------------------------------------------------------------
    // checking
    // ------------------------------------------------------------------------
    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    // each received byte is matched against the oldest note
    always @(posedge mclk)
    begin
        if (rx_stb)
            check_byte("read byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, rx_byte);
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------------
    task automatic hold_check();
        i_sssr_master_model.pause(1'b1);
        check_bit("held", 1'b1, held);
        check_bit("so enable", 1'b0, so_oe);
        i_sssr_master_model.wiggle(3);
        check_bit("held", 1'b1, held);
        check_bit("so enable", 1'b0, so_oe);
        i_sssr_master_model.pause(1'b0);
        check_bit("held", 1'b0, held);
        check_bit("so enable", 1'b1, so_oe);
    endtask : hold_check

    // byte exchange msb first; pz is the bit before which a pause is made, 8 for none
    task automatic xb(input logic [7:0] tx, input logic chk, input logic [7:0] exp, input int pz);
        logic [7:0] r;
        if (chk)
            exp_q.push_back(exp);
        for (int i = 7; i >= 0; i--)
        begin
            if (i == pz)
                hold_check();
            i_sssr_master_model.bit_x(tx[i], r[i]);
        end
        if (chk)
        begin
            rx_byte <= r;
            rx_stb  <= 1'b1;
            @(posedge mclk);
            rx_stb  <= 1'b0;
        end
    endtask : xb

    task automatic cmd(input logic [7:0] op, input logic [15:0] addr, input logic has_addr);
        i_sssr_master_model.select();
        xb(op, 1'b0, 8'h00, 8);
        if (has_addr)
        begin
            xb(addr[15:8], 1'b0, 8'h00, 8);
            xb(addr[7:0], 1'b0, 8'h00, 8);
        end
    endtask : cmd

    task automatic ends();
        i_sssr_master_model.deselect();
        check_bit("standby", 1'b1, standby);
        check_bit("so enable", 1'b0, so_oe);
    endtask : ends

    task automatic set_mode(input logic [7:0] v);
        cmd(write_status_cmd, 16'h0000, 1'b0);
        xb(v, 1'b0, 8'h00, 8);
        ends();
    endtask : set_mode

    initial
    begin
        logic [7:0] d [0:3];
        void'($urandom(32'he5402e5d));
        foreach (d[i])
            d[i] = 8'($urandom);
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        check_bit("standby", 1'b1, standby);
        check_bit("so enable", 1'b0, so_oe);
        // burst write over the top of the array, ignored top address bit set
        set_mode(8'h40);
        cmd(write_cmd, 16'hfffe, 1'b1);
        for (int i = 0; i < 3; i++)
            xb(d[i], 1'b0, 8'h00, 8);
        ends();
        // status read repeats the stored byte
        cmd(read_status_cmd, 16'h0000, 1'b0);
        xb(8'($urandom), 1'b1, 8'h40, 8);
        xb(8'($urandom), 1'b1, 8'h40, 8);
        ends();
        cmd(read_cmd, 16'h7ffe, 1'b1);
        for (int i = 0; i < 3; i++)
            xb(8'($urandom), 1'b1, d[i], 8);
        ends();
        // page write wraps to the page start, not into the next page
        set_mode(8'h80);
        cmd(write_cmd, 16'h001e, 1'b1);
        xb(d[3], 1'b0, 8'h00, 8);
        xb(d[0], 1'b0, 8'h00, 8);
        xb(d[1], 1'b0, 8'h00, 8);
        xb(d[2], 1'b0, 8'h00, 8);
        ends();
        cmd(read_cmd, 16'h001e, 1'b1);
        xb(8'($urandom), 1'b1, d[3], 8);
        xb(8'($urandom), 1'b1, d[0], 4);
        xb(8'($urandom), 1'b1, d[1], 8);
        xb(8'($urandom), 1'b1, d[2], 1);
        ends();
        // word mode repeats the same byte
        set_mode(8'h00);
        cmd(read_cmd, 16'h7ffe, 1'b1);
        xb(8'($urandom), 1'b1, d[0], 8);
        xb(8'($urandom), 1'b1, d[0], 8);
        ends();
        // unknown opcode never drives the output; the next selection starts afresh
        cmd(8'h07, 16'h0000, 1'b0);
        xb(8'($urandom), 1'b0, 8'h00, 8);
        check_bit("so enable", 1'b0, so_oe);
        ends();
        cmd(read_cmd, 16'h7fff, 1'b1);
        xb(8'($urandom), 1'b1, d[1], 8);
        ends();
        repeat (2) @(posedge mclk);
        stop_test();
    end

endmodule : sssr_slave_tb
